/* core/oaru_pkg.sv */
// Shared constants, encodings and helpers of the operand address and repeat unit
package oaru_pkg;

  localparam int DATA_W = 16;
  localparam int PAGE_W = 9;
  localparam int OFFS_W = 7;
  localparam int ARP_W = 3;
  localparam int NUM_AR = 8;
  localparam int SHORT_IMM_W = 8;
  localparam int CYC_W = 5;
  localparam int WAIT_W = 3;
  localparam int NUM_INT = 4;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;

  // Internal data-memory window, arbitrary default boundary
  localparam logic [DATA_W-1:0] INT_RAM_LO = 16'h0000;
  localparam logic [DATA_W-1:0] INT_RAM_HI = 16'h07ff;
  localparam logic [CYC_W-1:0] EXT_PENALTY = 5'h01;
  localparam logic [CYC_W-1:0] CYC_ONE = 5'h01;

  // Register map
  localparam logic [AXI_ADDR_W-1:0] REG_PAGE = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_ASEL = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_REPEAT_COUNTER = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_STAT = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] REG_AUX_BASE = 8'h20;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RPT_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_ARMED_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [PAGE_W-1:0] PAGE_RST = 9'h000;
  localparam logic [ARP_W-1:0] ARP_RST = 3'h0;
  localparam logic [DATA_W-1:0] AR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] REPEAT_COUNTER_RST = 16'h0000;

  typedef enum logic [2:0] {
    MODE_DIRECT = 3'b000,
    MODE_INDIRECT = 3'b001,
    MODE_SHORT = 3'b010,
    MODE_LONG = 3'b011,
    MODE_REG = 3'b100
  } oaru_mode_e;

  typedef enum logic [2:0] {
    UPD_NONE = 3'b000,
    UPD_INC = 3'b001,
    UPD_DEC = 3'b010,
    UPD_ADD0 = 3'b011,
    UPD_SUB0 = 3'b100,
    UPD_BRINC = 3'b101,
    UPD_BRDEC = 3'b110
  } oaru_upd_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RPTLD = 2'b10
  } oaru_state_e;

  // Bit reversal of a data word
  function automatic logic [DATA_W-1:0] oaru_bitrev(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [AXI_DATA_W-1:0] oaru_merge(input logic [AXI_DATA_W-1:0] old_v,
      input logic [AXI_DATA_W-1:0] new_v, input logic [AXI_STRB_W-1:0] strb);
    logic [AXI_DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < AXI_STRB_W; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Auxiliary register window decode
  function automatic logic oaru_is_aux(input logic [AXI_ADDR_W-1:0] a);
    return a[AXI_ADDR_W-1:5] == REG_AUX_BASE[AXI_ADDR_W-1:5];
  endfunction

  function automatic logic [ARP_W-1:0] oaru_aux_idx(input logic [AXI_ADDR_W-1:0] a);
    return a[4:2];
  endfunction

endpackage

/* core/oaru_ar_update.sv */
// Post-access update of the current auxiliary register
`timescale 1ns/10ps
module oaru_ar_update
  import oaru_pkg::*;
(
  // Operands
  input wire logic [DATA_W-1:0] ar_cur,
  input wire logic [DATA_W-1:0] ar_zero,
  input wire logic [2:0] upd,
  // Result
  output logic [DATA_W-1:0] ar_next
);

  always_comb begin
    unique case (upd)
      UPD_NONE: ar_next = ar_cur;
      UPD_INC: ar_next = ar_cur + 16'h0001;
      UPD_DEC: ar_next = ar_cur - 16'h0001;
      UPD_ADD0: ar_next = ar_cur + ar_zero;
      UPD_SUB0: ar_next = ar_cur - ar_zero;
      UPD_BRINC: ar_next = oaru_bitrev(oaru_bitrev(ar_cur) + oaru_bitrev(ar_zero));
      UPD_BRDEC: ar_next = oaru_bitrev(oaru_bitrev(ar_cur) - oaru_bitrev(ar_zero));
      default: ar_next = ar_cur;
    endcase
  end

endmodule

/* core/oaru_core.sv */
// Operand address generation and repeat control with AXI4-Lite access
//
// Function
// - Direct address is nine page bits above seven instruction offset bits.
// - Indirect address is the auxiliary register chosen by the select pointer.
// - Seven indirect update kinds, including bit-reversed increment and decrement.
// - Register operation in the instruction's cycle, then register and pointer update.
// - Short immediate operand comes from a field of the instruction word.
// - Long immediate operand comes from the instruction's second word.
// - Register mode passes a CPU register value without any address.
// - Repeat loads counter from addressed memory word, long immediate second word or 8-bit immediate.
// - Counter value N runs the following instruction N + 1 times.
// - Reset clears the repeat counter to zero.
// - After repeat decode all interrupts are held off until loop end.
// - Repeated multicycle instructions take one cycle plus any external operand penalty per further iteration.
// - Next instruction is fetched while the current one executes.
// - External operand access lengthens the instruction's cycle count, except for a repeat loading its counter from memory.
`timescale 1ns/10ps
module oaru_core
  import oaru_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Instruction from decode
  input wire logic ins_valid,
  output logic ins_ready,
  input wire logic [DATA_W-1:0] ins_word,
  input wire logic [DATA_W-1:0] ins_second,
  input wire logic [2:0] ins_mode,
  input wire logic [2:0] ins_upd,
  input wire logic ins_arp_load,
  input wire logic [ARP_W-1:0] ins_arp_new,
  input wire logic ins_is_repeat,
  input wire logic [CYC_W-1:0] ins_cycles,
  input wire logic [DATA_W-1:0] reg_operand,
  input wire logic page_load,
  input wire logic [PAGE_W-1:0] page_value,
  // Data memory
  input wire logic [DATA_W-1:0] dmem_rdata,
  input wire logic [WAIT_W-1:0] ext_wait,
  output logic [DATA_W-1:0] dmem_addr,
  output logic dmem_addr_valid,
  output logic [DATA_W-1:0] operand,
  output logic operand_valid,
  output logic exec_pulse,
  output logic fetch_req,
  // Interrupts
  input wire logic [NUM_INT-1:0] int_req,
  input wire logic nmi_req,
  output logic [NUM_INT-1:0] int_out,
  output logic nmi_out,
  output logic int_hold
);

  typedef struct packed {
    oaru_state_e st;
    logic [PAGE_W-1:0] page;
    logic [ARP_W-1:0] aux_select_pointer;
    logic [NUM_AR-1:0][DATA_W-1:0] ar;
    logic [DATA_W-1:0] repeat_counter;
    logic rpt_armed;
    logic rpt_run;
    logic hold;
    logic [CYC_W-1:0] cnt;
    logic [DATA_W-1:0] l_word;
    logic [DATA_W-1:0] l_second;
    logic [2:0] l_mode;
    logic [2:0] l_upd;
    logic l_arp_load;
    logic [ARP_W-1:0] l_arp_new;
    logic [CYC_W-1:0] l_cycles;
    logic ins_ready;
    logic [DATA_W-1:0] dmem_addr;
    logic dmem_addr_valid;
    logic [DATA_W-1:0] operand;
    logic operand_valid;
    logic exec_pulse;
    logic fetch_req;
    logic [NUM_INT-1:0] int_out;
    logic nmi_out;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic [AXI_DATA_W-1:0] wdata;
    logic [AXI_STRB_W-1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } oaru_regs_s;

  oaru_regs_s s_r;
  oaru_regs_s s_nxt;

  logic accept;
  logic reissue;
  logic [DATA_W-1:0] cur_word;
  logic [DATA_W-1:0] cur_second;
  logic [2:0] cur_mode;
  logic [2:0] cur_upd;
  logic cur_arp_load;
  logic [ARP_W-1:0] cur_arp_new;
  logic [CYC_W-1:0] cur_cycles;
  logic [DATA_W-1:0] ar_cur;
  logic [DATA_W-1:0] ar_new;

  assign accept = ins_valid && s_r.ins_ready;
  assign reissue = (s_r.st == ST_EXEC) && (s_r.cnt == CYC_ONE) && s_r.rpt_run &&
                   (s_r.repeat_counter != REPEAT_COUNTER_RST);
  assign cur_word = accept ? ins_word : s_r.l_word;
  assign cur_second = accept ? ins_second : s_r.l_second;
  assign cur_mode = accept ? ins_mode : s_r.l_mode;
  assign cur_upd = accept ? ins_upd : s_r.l_upd;
  assign cur_arp_load = accept ? ins_arp_load : s_r.l_arp_load;
  assign cur_arp_new = accept ? ins_arp_new : s_r.l_arp_new;
  assign cur_cycles = accept ? ins_cycles : s_r.l_cycles;
  assign ar_cur = s_r.ar[s_r.aux_select_pointer];

  oaru_ar_update u_ar_update (
    .ar_cur(ar_cur),
    .ar_zero(s_r.ar[0]),
    .upd(cur_upd),
    .ar_next(ar_new)
  );

  always_comb begin
    logic [DATA_W-1:0] addr_v;
    logic mem_mode;
    logic ext_v;
    logic [CYC_W-1:0] base_v;
    logic [CYC_W-1:0] pen_v;
    logic [AXI_DATA_W-1:0] mw;
    addr_v = '0;
    mem_mode = 1'b0;
    ext_v = 1'b0;
    base_v = '0;
    pen_v = '0;
    mw = '0;
    s_nxt = s_r;
    s_nxt.exec_pulse = 1'b0;
    s_nxt.fetch_req = 1'b0;
    s_nxt.dmem_addr_valid = 1'b0;
    s_nxt.operand_valid = 1'b0;

    // Write channels, taken in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      if (oaru_is_aux(s_r.awaddr)) begin
        mw = oaru_merge({16'h0000, s_r.ar[oaru_aux_idx(s_r.awaddr)]}, s_r.wdata, s_r.wstrb);
        s_nxt.ar[oaru_aux_idx(s_r.awaddr)] = mw[DATA_W-1:0];
      end else if (s_r.awaddr[AXI_ADDR_W-1:2] == REG_PAGE[AXI_ADDR_W-1:2]) begin
        mw = oaru_merge({23'h000000, s_r.page}, s_r.wdata, s_r.wstrb);
        s_nxt.page = mw[PAGE_W-1:0];
      end else if (s_r.awaddr[AXI_ADDR_W-1:2] == REG_ASEL[AXI_ADDR_W-1:2]) begin
        mw = oaru_merge({29'h00000000, s_r.aux_select_pointer}, s_r.wdata, s_r.wstrb);
        s_nxt.aux_select_pointer = mw[ARP_W-1:0];
      end else if (s_r.awaddr[AXI_ADDR_W-1:2] != REG_REPEAT_COUNTER[AXI_ADDR_W-1:2] &&
                   s_r.awaddr[AXI_ADDR_W-1:2] != REG_STAT[AXI_ADDR_W-1:2]) begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end

    // Read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = '0;
      if (oaru_is_aux(s_axi_araddr)) begin
        s_nxt.rdata[DATA_W-1:0] = s_r.ar[oaru_aux_idx(s_axi_araddr)];
      end else if (s_axi_araddr[AXI_ADDR_W-1:2] == REG_PAGE[AXI_ADDR_W-1:2]) begin
        s_nxt.rdata[PAGE_W-1:0] = s_r.page;
      end else if (s_axi_araddr[AXI_ADDR_W-1:2] == REG_ASEL[AXI_ADDR_W-1:2]) begin
        s_nxt.rdata[ARP_W-1:0] = s_r.aux_select_pointer;
      end else if (s_axi_araddr[AXI_ADDR_W-1:2] == REG_REPEAT_COUNTER[AXI_ADDR_W-1:2]) begin
        s_nxt.rdata[DATA_W-1:0] = s_r.repeat_counter;
      end else if (s_axi_araddr[AXI_ADDR_W-1:2] == REG_STAT[AXI_ADDR_W-1:2]) begin
        s_nxt.rdata[STAT_BUSY_BIT] = (s_r.st != ST_IDLE);
        s_nxt.rdata[STAT_RPT_BIT] = s_r.rpt_run;
        s_nxt.rdata[STAT_HOLD_BIT] = s_r.hold;
        s_nxt.rdata[STAT_ARMED_BIT] = s_r.rpt_armed;
      end else begin
        s_nxt.rresp = RESP_SLVERR;
      end
    end

    // Sequencing
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.ins_ready = 1'b1;
      end
      ST_EXEC: begin
        if (s_r.cnt > CYC_ONE) begin
          s_nxt.cnt = s_r.cnt - CYC_ONE;
        end else if (!reissue) begin
          s_nxt.st = ST_IDLE;
          s_nxt.ins_ready = 1'b1;
          if (s_r.rpt_run) begin
            s_nxt.rpt_run = 1'b0;
            s_nxt.hold = 1'b0;
          end
        end
      end
      ST_RPTLD: begin
        s_nxt.repeat_counter = dmem_rdata;
        s_nxt.rpt_armed = 1'b1;
        s_nxt.st = ST_IDLE;
        s_nxt.ins_ready = 1'b1;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Issue of one execution, new or repeated
    if (accept || reissue) begin
      mem_mode = (cur_mode == MODE_DIRECT) || (cur_mode == MODE_INDIRECT);
      if (cur_mode == MODE_DIRECT) begin
        addr_v = {s_r.page, cur_word[OFFS_W-1:0]};
      end else begin
        addr_v = ar_cur;
      end
      ext_v = mem_mode && ((addr_v < INT_RAM_LO) || (addr_v > INT_RAM_HI));
      base_v = (reissue || cur_cycles == '0) ? CYC_ONE : cur_cycles;
      pen_v = ext_v ? (EXT_PENALTY + {2'b00, ext_wait}) : '0;
      s_nxt.cnt = base_v + pen_v;
      s_nxt.st = ST_EXEC;
      s_nxt.exec_pulse = 1'b1;
      if (mem_mode) begin
        s_nxt.dmem_addr = addr_v;
        s_nxt.dmem_addr_valid = 1'b1;
      end else begin
        s_nxt.operand_valid = 1'b1;
        unique case (cur_mode)
          MODE_SHORT: s_nxt.operand = {8'h00, cur_word[SHORT_IMM_W-1:0]};
          MODE_LONG: s_nxt.operand = cur_second;
          default: s_nxt.operand = reg_operand;
        endcase
      end
      if (cur_mode == MODE_INDIRECT) begin
        s_nxt.ar[s_r.aux_select_pointer] = ar_new;
        if (cur_arp_load) begin
          s_nxt.aux_select_pointer = cur_arp_new;
        end
      end
      if (reissue) begin
        s_nxt.repeat_counter = s_r.repeat_counter - 16'h0001;
      end
      if (accept) begin
        s_nxt.ins_ready = 1'b0;
        s_nxt.fetch_req = 1'b1;
        s_nxt.l_word = ins_word;
        s_nxt.l_second = ins_second;
        s_nxt.l_mode = ins_mode;
        s_nxt.l_upd = ins_upd;
        s_nxt.l_arp_load = ins_arp_load;
        s_nxt.l_arp_new = ins_arp_new;
        s_nxt.l_cycles = ins_cycles;
        if (ins_is_repeat) begin
          s_nxt.hold = 1'b1;
          s_nxt.rpt_armed = 1'b0;
          if (mem_mode) begin
            s_nxt.st = ST_RPTLD;
          end else if (cur_mode == MODE_LONG) begin
            s_nxt.repeat_counter = cur_second;
            s_nxt.rpt_armed = 1'b1;
          end else begin
            s_nxt.repeat_counter = {8'h00, cur_word[SHORT_IMM_W-1:0]};
            s_nxt.rpt_armed = 1'b1;
          end
        end else if (s_r.rpt_armed) begin
          s_nxt.rpt_armed = 1'b0;
          s_nxt.rpt_run = 1'b1;
        end
      end
    end

    if (page_load) begin
      s_nxt.page = page_value;
    end

    // Interrupt gating while a repeat is pending or running
    s_nxt.int_out = s_nxt.hold ? '0 : int_req;
    s_nxt.nmi_out = s_nxt.hold ? 1'b0 : nmi_req;

    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.page <= PAGE_RST;
      s_r.aux_select_pointer <= ARP_RST;
      s_r.ar <= {NUM_AR{AR_RST}};
      s_r.repeat_counter <= REPEAT_COUNTER_RST;
      s_r.l_mode <= MODE_DIRECT;
      s_r.l_upd <= UPD_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign ins_ready = s_r.ins_ready;
  assign dmem_addr = s_r.dmem_addr;
  assign dmem_addr_valid = s_r.dmem_addr_valid;
  assign operand = s_r.operand;
  assign operand_valid = s_r.operand_valid;
  assign exec_pulse = s_r.exec_pulse;
  assign fetch_req = s_r.fetch_req;
  assign int_out = s_r.int_out;
  assign nmi_out = s_r.nmi_out;
  assign int_hold = s_r.hold;

endmodule

/* sim/oaru_chk.sv */
// Port-level checks of the operand address and repeat unit
`timescale 1ns/10ps
module oaru_chk
  import oaru_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Instruction
  input wire logic ins_valid,
  input wire logic ins_ready,
  input wire logic [DATA_W-1:0] ins_word,
  input wire logic [DATA_W-1:0] ins_second,
  input wire logic [2:0] ins_mode,
  input wire logic ins_is_repeat,
  input wire logic [DATA_W-1:0] reg_operand,
  // Results
  input wire logic [DATA_W-1:0] dmem_addr,
  input wire logic dmem_addr_valid,
  input wire logic [DATA_W-1:0] operand,
  input wire logic operand_valid,
  input wire logic exec_pulse,
  input wire logic fetch_req,
  // Interrupts
  input wire logic [NUM_INT-1:0] int_out,
  input wire logic nmi_out,
  input wire logic int_hold
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic acc;
  assign acc = ins_valid && ins_ready;
  property p_dir;
    acc && ins_mode == MODE_DIRECT |=> dmem_addr_valid && dmem_addr[6:0] == $past(ins_word[6:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direct address low bits wrong");
  property p_ind;
    acc && ins_mode == MODE_INDIRECT |=> dmem_addr_valid && !operand_valid;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect access not issued");
  property p_short;
    acc && ins_mode == MODE_SHORT |=> operand_valid && operand[7:0] == $past(ins_word[7:0]);
  endproperty
  a_short: assert property (p_short) else $error("short operand wrong");
  property p_long;
    acc && ins_mode == MODE_LONG |=> operand_valid && operand == $past(ins_second);
  endproperty
  a_long: assert property (p_long) else $error("long operand wrong");
  property p_reg;
    acc && ins_mode == MODE_REG |=> operand == $past(reg_operand) && !dmem_addr_valid;
  endproperty
  a_reg: assert property (p_reg) else $error("register operand wrong");
  property p_fetch;
    acc |=> exec_pulse && fetch_req && !ins_ready;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no issue and prefetch");
  property p_arm;
    acc && ins_is_repeat |=> int_hold;
  endproperty
  a_arm: assert property (p_arm) else $error("hold not raised by repeat");
  property p_mask;
    int_hold |-> int_out == '0 && !nmi_out;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt passed during hold");
  property p_end;
    $fell(int_hold) |=> ins_ready;
  endproperty
  a_end: assert property (p_end) else $error("not ready after loop end");
  c_rpt: cover property (acc && ins_is_repeat);
  c_iter: cover property (exec_pulse && int_hold [*3]);
  c_fall: cover property ($fell(int_hold));
endmodule

/* sim/oaru_core_tb_top.sv */
// Self-checking bench of the operand address and repeat unit
`timescale 1ns/10ps
module oaru_core_tb_top;
  import oaru_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, ins_ready, dmem_addr_valid, operand_valid;
  logic exec_pulse, fetch_req, nmi_out, int_hold, ins_valid = 0, ins_arp_load = 0;
  logic ins_is_repeat = 0, page_load = 0, nmi_req = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, int_req = 0, int_out;
  logic [15:0] ins_word = 0, ins_second = 0, reg_operand = 0, dmem_rdata = 16'h0001;
  logic [15:0] dmem_addr, operand, a;
  logic [2:0] ins_mode = 0, ins_upd = 0, ins_arp_new = 0, ext_wait = 0;
  logic [4:0] ins_cycles = 1;
  logic [8:0] page_value = 0;
  int errors = 0, checks = 0, ex, cyc, b;
  oaru_core DUT (.*);
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk("bresp", RESP_OKAY, s_axi_bresp);
  endtask
  task automatic axr(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic ins(input logic [2:0] m, u, input logic [15:0] w, input logic r,
      input logic [4:0] c);
    @(posedge aclk);
    ins_mode <= m;
    ins_upd <= u;
    ins_word <= w;
    ins_is_repeat <= r;
    ins_cycles <= c;
    ins_valid <= 1;
    do @(posedge aclk); while (ins_ready !== 1'b1);
    ins_valid <= 0;
    ex = 0;
    cyc = 0;
    do begin
      @(posedge aclk);
      cyc++;
      if (exec_pulse === 1'b1) ex++;
    end while (ins_ready !== 1'b1 && cyc < 100);
  endtask
  function automatic logic [15:0] rv(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      rv[i] = v[15-i];
    end
  endfunction
  function automatic logic [15:0] nx(input logic [2:0] u, input logic [15:0] v, z);
    case (u)
      3'h1: nx = v + 16'h0001;
      3'h2: nx = v - 16'h0001;
      3'h3: nx = v + z;
      3'h4: nx = v - z;
      3'h5: nx = rv(rv(v) + rv(z));
      3'h6: nx = rv(rv(v) - rv(z));
      default: nx = v;
    endcase
  endfunction
  task automatic t_reset();
    axr(REG_REPEAT_COUNTER);
    chk("repeat_counter", 32'h0, rd);
    axr(8'h80);
    chk("rresp", RESP_SLVERR, rsp);
    $display("reset test done");
  endtask
  task automatic t_direct();
    ins(MODE_DIRECT, 0, 16'h0010, 0, 1);
    b = cyc;
    axw(REG_PAGE, 32'h1ab);
    ext_wait <= 2;
    ins(MODE_DIRECT, 0, 16'hff55, 0, 1);
    chk("daddr", {9'h1ab, 7'h55}, dmem_addr);
    chk("ext cycles", b + 3, cyc);
    ext_wait <= 0;
    @(posedge aclk);
    page_load <= 1;
    page_value <= 9'h003;
    @(posedge aclk);
    page_load <= 0;
    ins(MODE_DIRECT, 0, 16'h0010, 0, 1);
    chk("daddr", {9'h003, 7'h10}, dmem_addr);
    chk("int cycles", b, cyc);
    $display("direct test done");
  endtask
  task automatic t_indirect();
    axw(REG_AUX_BASE, 32'h0008);
    axw(REG_AUX_BASE + 8'h08, 32'h0100);
    axw(REG_ASEL, 32'h2);
    a = 16'h0100;
    for (int k = 0; k < 7; k++) begin
      ins(MODE_INDIRECT, 3'((k + 1) % 7), 16'h0, 0, 1);
      chk("iaddr", a, dmem_addr);
      a = nx(3'((k + 1) % 7), a, 16'h0008);
    end
    axr(REG_AUX_BASE + 8'h08);
    chk("ar2", a, rd);
    ins_arp_load <= 1;
    ins_arp_new <= 5;
    ins(MODE_INDIRECT, 0, 16'h0, 0, 1);
    axr(REG_ASEL);
    chk("asel", 32'h5, rd);
    ins_arp_new <= 3;
    ins(MODE_SHORT, 0, 16'h0, 0, 1);
    ins_arp_load <= 0;
    axr(REG_ASEL);
    chk("asel", 32'h5, rd);
    $display("indirect test done");
  endtask
  task automatic t_imm();
    ins_second <= 16'hbeef;
    reg_operand <= 16'h1234;
    ins(MODE_SHORT, 0, 16'h3c5a, 0, 1);
    chk("short", 8'h5a, operand[7:0]);
    ins(MODE_LONG, 0, 16'h0, 0, 1);
    chk("long", 16'hbeef, operand);
    ins(MODE_REG, 0, 16'h0, 0, 1);
    chk("reg", 16'h1234, operand);
    $display("immediate test done");
  endtask
  task automatic t_repeat();
    int_req <= 4'ha;
    nmi_req <= 1;
    ins(MODE_SHORT, 0, 16'h0002, 1, 1);
    axr(REG_REPEAT_COUNTER);
    chk("repeat_counter", 32'h2, rd);
    chk("masked", 5'h0, {nmi_out, int_out});
    ins(MODE_SHORT, 0, 16'h0, 0, 3);
    chk("runs", 3, ex);
    chk("rpt cycles", b + 4, cyc);
    @(posedge aclk);
    chk("unmasked", 5'h1a, {nmi_out, int_out});
    ins_second <= 16'h0;
    ins(MODE_LONG, 0, 16'h0, 1, 1);
    ins(MODE_SHORT, 0, 16'h0, 0, 1);
    chk("runs", 1, ex);
    ins(MODE_DIRECT, 0, 16'h0010, 1, 1);
    axr(REG_REPEAT_COUNTER);
    chk("repeat_counter", 32'h1, rd);
    ins(MODE_SHORT, 0, 16'h0, 0, 1);
    chk("runs", 2, ex);
    ins(MODE_SHORT, 0, 16'h0005, 1, 1);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    axr(REG_REPEAT_COUNTER);
    chk("repeat_counter", 32'h0, rd);
    chk("hold", 1'b0, int_hold);
    $display("repeat test done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_direct();
    t_indirect();
    t_imm();
    t_repeat();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    final_report();
  end
endmodule
bind oaru_core oaru_chk u_chk (.aclk, .aresetn, .ins_valid, .ins_ready, .ins_word,
  .ins_second, .ins_mode, .ins_is_repeat, .reg_operand, .dmem_addr, .dmem_addr_valid,
  .operand, .operand_valid, .exec_pulse, .fetch_req, .int_out, .nmi_out, .int_hold);
